//--- common/occ_defines.svh
// Command codes, field positions, sizes and timing counts for the OTP/CRC option commands
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// ****************************************
// Command codes
// ****************************************
`define OCC_CMD_CRC_CALC      8'h34
`define OCC_CMD_CRC_READ      8'h35
`define OCC_CMD_OTP_PROG      8'h36
`define OCC_CMD_WR_OPTION     8'h37
`define OCC_CMD_WR_USER_IDENTIFIER    8'h38

// ****************************************
// Register sizes and field positions
// ****************************************
`define OCC_REG_BYTES         4'ha
`define OCC_REG_LAST          4'h9
`define OCC_MODE_LO_BYTE      4'h1
`define OCC_MODE_HI_BYTE      4'h5
`define OCC_WS_BITS           36
`define OCC_DBUF_BIT          6
`define OCC_BYTE_F            5
`define OCC_OPT_RESET         80'h0
`define OCC_UID_RESET         80'h0
`define OCC_CRC_INIT          16'hffff
`define OCC_CRC_POLY          16'h1021

// ****************************************
// Timing
// ****************************************
`define OCC_PROG_CYCLES       16'h0100

`endif

//--- common/occ_pkg.sv
// Types shared by both ends of the OTP/CRC option command link
package occ_pkg;
    // Device command interpreter states
    typedef enum logic [2:0] {
        OCC_IDLE     = 3'b000,
        OCC_CRC_RUN  = 3'b001,
        OCC_PROG_RUN = 3'b010,
        OCC_RD_CRC   = 3'b011,
        OCC_WR_OPT   = 3'b100,
        OCC_WR_UID   = 3'b101
    } occ_dev_state_t;

    // Host sequencer states
    typedef enum logic [2:0] {
        OCH_IDLE   = 3'b000,
        OCH_CMD    = 3'b001,
        OCH_DATA   = 3'b010,
        OCH_READ   = 3'b011,
        OCH_WAIT   = 3'b100
    } occ_host_state_t;

    // Byte of serial-interface traffic
    typedef logic [7:0] occ_byte_t;
endpackage : occ_pkg

//--- common/occ_if.sv
// Interface joining host and device over the byte-level command link
`timescale 1ns/1ps
interface occ_if;
    logic               wr_valid;   // Host writes a byte this cycle
    logic               rd_valid;   // Host reads a byte this cycle
    logic               dc_sel;     // Data/command select: 0 command, 1 data
    occ_pkg::occ_byte_t wr_byte;    // Byte from host
    occ_pkg::occ_byte_t rd_byte;    // Byte to host
    logic               busy;       // Device busy level

    modport device (input wr_valid, input rd_valid, input dc_sel, input wr_byte,
                    output rd_byte, output busy);
    modport host   (output wr_valid, output rd_valid, output dc_sel, output wr_byte,
                    input rd_byte, input busy);
endinterface : occ_if

//--- hw/occ_device.sv
// Device end: command interpreter for CRC, OTP programming and option registers
`timescale 1ns/1ps
`include "occ_defines.svh"
module occ_device #(
    parameter int PROG_CYCLES = `OCC_PROG_CYCLES  // Duration of OTP programming
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    // Command link
    occ_if.device                       link,
    // OTP storage image
    input  wire logic [159:0]           otp_image,
    input  wire logic                   internal_clock_enabled,
    output logic      [159:0]           otp_prog_data,
    output logic                        otp_prog_strobe,
    // Display controls
    output logic [`OCC_WS_BITS-1:0]     waveform_state_mode,
    output logic                        ram_double_buffering,
    output logic [31:0]                 module_version,
    output logic [15:0]                 otp_checksum_result
);
    import occ_pkg::*;

    // ****************************************
    // State
    // ****************************************
    occ_dev_state_t state, next_state;      // Interpreter state
    logic [79:0]    display_option_settings, next_opt;  // Option register
    logic [79:0]    user_identifier, next_uid;          // User_identifier register
    logic [3:0]     byte_idx, next_byte_idx;            // Parameter byte counter
    logic [7:0]     bit_idx, next_bit_idx;              // CRC bit walker over OTP
    logic [15:0]    crc, next_crc;                      // CRC accumulator / result
    logic [15:0]    prog_cnt, next_prog_cnt;            // Programming timer
    logic [159:0]   prog_data, next_prog_data;          // Programming image
    logic           prog_stb, next_prog_stb;            // Programming strobe
    occ_byte_t      rd_byte_q, next_rd_byte;            // Read data
    logic           cmd_wr;                             // Command byte this cycle
    logic           dat_wr;                             // Parameter byte this cycle

    // Place a byte at index idx (A is byte 0, in the top bits) of an 80-bit register
    function automatic logic [79:0] put_byte(input logic [79:0] r, input logic [3:0] idx,
                                             input occ_byte_t b);
        logic [79:0] v;
        v = r;
        v[79 - 8*idx -: 8] = b;
        return v;
    endfunction : put_byte

    // One CRC-CCITT step on a single bit
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
        logic fb;
        fb = c[15] ^ d;
        return {c[14:0], 1'b0} ^ (fb ? `OCC_CRC_POLY : 16'h0000);
    endfunction : crc_step

    // Commands with DC low, parameters with DC high
    assign cmd_wr = link.wr_valid && !link.dc_sel;
    assign dat_wr = link.wr_valid && link.dc_sel;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_state     = state;
        next_opt       = display_option_settings;
        next_uid       = user_identifier;
        next_byte_idx  = byte_idx;
        next_bit_idx   = bit_idx;
        next_crc       = crc;
        next_prog_cnt  = prog_cnt;
        next_prog_data = prog_data;
        next_prog_stb  = 1'b0;
        next_rd_byte   = rd_byte_q;
        unique case (state)
            OCC_CRC_RUN: begin
                // Walk the OTP image one bit a cycle; commands are ignored meanwhile
                next_crc     = crc_step(crc, otp_image[8'd159 - bit_idx]);
                next_bit_idx = bit_idx + 8'h01;
                if (bit_idx == 8'd159) begin
                    next_state = OCC_IDLE;      // Busy falls here
                end
            end
            OCC_PROG_RUN: begin
                next_prog_cnt = prog_cnt - 16'h0001;
                if (prog_cnt == 16'h0001) begin
                    next_state = OCC_IDLE;
                end
            end
            default: begin
                // Idle, CRC-read and parameter-collection states accept new commands
                if (cmd_wr) begin
                    next_byte_idx = 4'h0;
                    next_state    = OCC_IDLE;
                    if (link.wr_byte == `OCC_CMD_CRC_CALC) begin
                        next_state   = OCC_CRC_RUN;
                        next_crc     = `OCC_CRC_INIT;
                        next_bit_idx = 8'h00;
                    end else if (link.wr_byte == `OCC_CMD_CRC_READ) begin
                        next_state   = OCC_RD_CRC;
                        next_rd_byte = crc[15:8];
                    end else if (link.wr_byte == `OCC_CMD_OTP_PROG) begin
                        // Both registers, all twenty bytes, go to OTP
                        next_state     = OCC_PROG_RUN;
                        next_prog_cnt  = PROG_CYCLES[15:0];
                        next_prog_data = {display_option_settings, user_identifier};
                        next_prog_stb  = internal_clock_enabled;
                    end else if (link.wr_byte == `OCC_CMD_WR_OPTION) begin
                        next_state = OCC_WR_OPT;
                    end else if (link.wr_byte == `OCC_CMD_WR_USER_IDENTIFIER) begin
                        next_state = OCC_WR_UID;
                    end
                end else if (dat_wr && state == OCC_WR_OPT) begin
                    next_opt      = put_byte(display_option_settings, byte_idx,
                                             link.wr_byte);
                    next_byte_idx = byte_idx + 4'h1;
                    if (byte_idx == `OCC_REG_LAST) begin
                        next_state = OCC_IDLE;
                    end
                end else if (dat_wr && state == OCC_WR_UID) begin
                    // Extra bytes beyond J are dropped
                    next_uid      = put_byte(user_identifier, byte_idx, link.wr_byte);
                    next_byte_idx = byte_idx + 4'h1;
                    if (byte_idx == `OCC_REG_LAST) begin
                        next_state = OCC_IDLE;
                    end
                end else if (link.rd_valid && state == OCC_RD_CRC) begin
                    // Second read gives the low byte, then the read ends
                    next_byte_idx = byte_idx + 4'h1;
                    next_rd_byte  = crc[7:0];
                    if (byte_idx == 4'h1) begin
                        next_state = OCC_IDLE;
                    end
                end
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state                   <= OCC_IDLE;
            display_option_settings <= `OCC_OPT_RESET;
            user_identifier         <= `OCC_UID_RESET;
            byte_idx                <= 4'h0;
            bit_idx                 <= 8'h00;
            crc                     <= 16'h0000;
            prog_cnt                <= 16'h0000;
            prog_data               <= 160'h0;
            prog_stb                <= 1'b0;
            rd_byte_q               <= 8'h00;
        end else if (clk_en) begin
            state                   <= next_state;
            display_option_settings <= next_opt;
            user_identifier         <= next_uid;
            byte_idx                <= next_byte_idx;
            bit_idx                 <= next_bit_idx;
            crc                     <= next_crc;
            prog_cnt                <= next_prog_cnt;
            prog_data               <= next_prog_data;
            prog_stb                <= next_prog_stb;
            rd_byte_q               <= next_rd_byte;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Busy as a decode of state keeps it exact to the operation's span
    assign link.busy    = (state == OCC_CRC_RUN) || (state == OCC_PROG_RUN);
    assign link.rd_byte = rd_byte_q;
    assign otp_prog_data   = prog_data;
    assign otp_prog_strobe = prog_stb;
    assign otp_checksum_result = crc;
    // Byte B holds states 7..0, byte E states 31..24, low nibble of F states 35..32
    assign waveform_state_mode = {display_option_settings[35:32],
                                  display_option_settings[47:40],
                                  display_option_settings[55:48],
                                  display_option_settings[63:56],
                                  display_option_settings[71:64]};
    // Double-buffering only counts where some state selects mode 2
    assign ram_double_buffering =
        display_option_settings[8*(`OCC_REG_LAST - `OCC_BYTE_F) + `OCC_DBUF_BIT] &&
        (|waveform_state_mode);
    assign module_version = display_option_settings[31:0];
endmodule : occ_device

//--- hw/occ_host.sv
// Host end: sequences command and parameter bytes and reads back the CRC
`timescale 1ns/1ps
`include "occ_defines.svh"
module occ_host (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    // User request
    input  wire logic                   req_valid,
    input  wire occ_pkg::occ_byte_t     req_cmd,
    input  wire logic [79:0]            req_data,
    output logic                        req_ready,
    output logic [15:0]                 crc_value,
    output logic                        crc_done,
    // Command link
    occ_if.host                         link
);
    import occ_pkg::*;

    // ****************************************
    // State
    // ****************************************
    occ_host_state_t state, next_state;   // Sequencer state
    occ_byte_t       cmd, next_cmd;       // Held command
    logic [79:0]     data, next_data;     // Held parameters
    logic [3:0]      cnt, next_cnt;       // Byte counter
    logic [15:0]     crc_q, next_crc_q;   // Captured CRC
    logic            done, next_done;     // CRC capture pulse
    logic [2:0]      busy_sync;           // Busy synchroniser, three stages
    logic            busy_s;              // Agreed busy level
    logic            next_busy_s;

    // Busy counts once the second and third stages agree
    always_comb begin
        next_busy_s = busy_s;
        if (busy_sync[1] == busy_sync[2]) begin
            next_busy_s = busy_sync[2];
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_state = state;
        next_cmd   = cmd;
        next_data  = data;
        next_cnt   = cnt;
        next_crc_q = crc_q;
        next_done  = 1'b0;
        unique case (state)
            OCH_IDLE: begin
                if (req_valid && !busy_s) begin
                    next_state = OCH_CMD;
                    next_cmd   = req_cmd;
                    next_data  = req_data;
                    next_cnt   = 4'h0;
                end
            end
            OCH_CMD: begin
                if (cmd == `OCC_CMD_WR_OPTION || cmd == `OCC_CMD_WR_USER_IDENTIFIER) begin
                    next_state = OCH_DATA;
                end else if (cmd == `OCC_CMD_CRC_READ) begin
                    next_state = OCH_READ;
                end else begin
                    next_state = OCH_WAIT;
                end
            end
            OCH_DATA: begin
                next_data = {data[71:0], 8'h00};
                next_cnt  = cnt + 4'h1;
                if (cnt == `OCC_REG_LAST) begin
                    next_state = OCH_WAIT;
                end
            end
            OCH_READ: begin
                // Each read strobe takes the byte standing on rd_byte at that edge
                next_cnt   = cnt + 4'h1;
                next_crc_q = {crc_q[7:0], link.rd_byte};
                if (cnt == 4'h1) begin
                    next_done  = 1'b1;
                    next_state = OCH_WAIT;
                end
            end
            default: begin
                // Settle four cycles for the synchronised busy, then wait it out
                next_cnt = cnt + 4'h1;
                if (cnt[3:2] != 2'b00 && !busy_s) begin
                    next_state = OCH_IDLE;
                end
            end
        endcase
        if (state == OCH_DATA && cnt == `OCC_REG_LAST) begin
            next_cnt = 4'h0;
        end
        if (state == OCH_READ && cnt == 4'h1) begin
            next_cnt = 4'h0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= OCH_IDLE;
            cmd       <= 8'h00;
            data      <= 80'h0;
            cnt       <= 4'h0;
            crc_q     <= 16'h0000;
            done      <= 1'b0;
            busy_sync <= 3'b000;
            busy_s    <= 1'b0;
        end else if (clk_en) begin
            state     <= next_state;
            cmd       <= next_cmd;
            data      <= next_data;
            cnt       <= next_cnt;
            crc_q     <= next_crc_q;
            done      <= next_done;
            busy_sync <= {busy_sync[1:0], link.busy};
            busy_s    <= next_busy_s;
        end
    end

    // ****************************************
    // Link drive
    // ****************************************
    assign link.wr_valid = (state == OCH_CMD) || (state == OCH_DATA);
    assign link.dc_sel   = (state != OCH_CMD);
    assign link.wr_byte  = (state == OCH_CMD) ? cmd : data[79:72];
    assign link.rd_valid = (state == OCH_READ);
    assign req_ready     = (state == OCH_IDLE) && !busy_s;
    assign crc_value     = crc_q;
    assign crc_done      = done;
endmodule : occ_host

//--- dv/occ_link_chk.sv
// Checker of the byte-level command link between host and device
`timescale 1ns/1ps
`include "occ_defines.svh"
module occ_link_chk #(
    parameter int PROG_CYCLES = `OCC_PROG_CYCLES  // Programming span given to the device
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_b,
    // Link signals
    input wire logic               wr_valid,
    input wire logic               rd_valid,
    input wire logic               dc_sel,
    input wire occ_pkg::occ_byte_t wr_byte,
    input wire occ_pkg::occ_byte_t rd_byte,
    input wire logic               busy
);
    import occ_pkg::*;
    // ****************************************
    // Helper decode and busy run counter
    // ****************************************
    logic        cmd_any;  // Command byte on the link
    logic        cmd34;    // CRC start seen while idle
    logic        cmd35;    // CRC read seen while idle
    logic        cmd36;    // Programming start seen while idle
    logic        cmd_reg;  // Option or user_identifier write seen while idle
    logic [15:0] run_len;  // Busy cycles so far
    logic [1:0]  kind;     // 1 CRC, 2 programming
    assign cmd_any = wr_valid && !dc_sel;
    assign cmd34   = cmd_any && !busy && wr_byte == `OCC_CMD_CRC_CALC;
    assign cmd35   = cmd_any && !busy && wr_byte == `OCC_CMD_CRC_READ;
    assign cmd36   = cmd_any && !busy && wr_byte == `OCC_CMD_OTP_PROG;
    assign cmd_reg = cmd_any && !busy &&
                     (wr_byte == `OCC_CMD_WR_OPTION || wr_byte == `OCC_CMD_WR_USER_IDENTIFIER);
    // Counts only while busy, so a refused command never restarts the run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_len <= 16'h0;
            kind    <= 2'h0;
        end else begin
            run_len <= busy ? run_len + 16'h1 : 16'h0;
            if (cmd34) begin
                kind <= 2'h1;
            end else if (cmd36) begin
                kind <= 2'h2;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ****************************************
    // Transfer sequences
    // ****************************************
    sequence s_ten_bytes;
        (wr_valid && dc_sel)[*8] ##1 (wr_valid && dc_sel)[*2] ##1 !wr_valid;
    endsequence
    sequence s_two_reads;
        ##[1:20] rd_valid ##[1:20] rd_valid;
    endsequence
    a_crc_busy_rise: assert property (cmd34 |=> busy)
        else $error("busy did not rise after CRC start");
    a_prog_busy_rise: assert property (cmd36 |=> busy)
        else $error("busy did not rise after programming start");
    a_busy_cause: assert property ($rose(busy) |-> $past(cmd34 || cmd36))
        else $error("busy rose without an operation");
    a_crc_busy_len: assert property ($fell(busy) && kind == 2'h1 |-> run_len == 16'd160)
        else $error("CRC busy span wrong");
    a_prog_busy_len: assert property ($fell(busy) && kind == 2'h2 |-> run_len == PROG_CYCLES)
        else $error("programming busy span wrong");
    a_read_dc_high: assert property (rd_valid |-> dc_sel && !wr_valid)
        else $error("read strobe without data select");
    a_read_two_bytes: assert property (cmd35 |-> s_two_reads)
        else $error("CRC read did not take two bytes");
    a_rd_byte_hold: assert property (!$past(rd_valid) && !$past(rd_valid, 2) && !$past(cmd35)
        && !$past(cmd35, 2) |-> $stable(rd_byte))
        else $error("read byte changed without a read");
    a_ten_data_bytes: assert property (cmd_reg |=> s_ten_bytes)
        else $error("register write not ten data bytes");
    a_cmd_not_busy: assert property (busy && $past(busy, 4) |-> !cmd_any)
        else $error("command sent while busy");
endmodule : occ_link_chk

//--- dv/testbench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
`include "occ_defines.svh"
module testbench;
    import occ_pkg::*;
    localparam int PROG = 4;  // Short programming span keeps the run brief
    logic clk, rst_b, req_valid, req_ready, crc_done, otp_prog_strobe, ram_double_buffering;
    logic internal_clock_enabled;
    occ_byte_t req_cmd;
    logic [79:0] req_data, opt_v;
    logic [159:0] otp_image, otp_prog_data;
    logic [15:0] crc_value, otp_checksum_result;
    logic [35:0] waveform_state_mode;
    logic [31:0] module_version;
    int mismatches, checked, strobes, crc_hits;
    occ_if link_if();
    occ_device #(.PROG_CYCLES(PROG)) i_occ_device (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
        .link(link_if), .otp_image(otp_image), .internal_clock_enabled(internal_clock_enabled),
        .otp_prog_data(otp_prog_data), .otp_prog_strobe(otp_prog_strobe),
        .waveform_state_mode(waveform_state_mode), .ram_double_buffering(ram_double_buffering),
        .module_version(module_version), .otp_checksum_result(otp_checksum_result));
    occ_host i_occ_host (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_data(req_data), .req_ready(req_ready), .crc_value(crc_value),
        .crc_done(crc_done), .link(link_if));
    occ_link_chk #(.PROG_CYCLES(PROG)) i_occ_link_chk (.clk(clk), .rst_b(rst_b),
        .wr_valid(link_if.wr_valid), .rd_valid(link_if.rd_valid), .dc_sel(link_if.dc_sel),
        .wr_byte(link_if.wr_byte), .rd_byte(link_if.rd_byte), .busy(link_if.busy));
    // ****************************************
    // Clock, pulse counters and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Pulses last one cycle, so they are counted rather than polled
    always @(posedge clk) begin
        if (otp_prog_strobe === 1'b1) strobes++;
        if (crc_done === 1'b1) crc_hits++;
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [159:0] seen, input logic [159:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Waits for the host to be ready, bounded so a hang is reported
    task automatic wait_ready();
        int n;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("req_ready", req_ready, 1'b1);
    endtask : wait_ready
    task automatic send(input occ_byte_t cmd, input logic [79:0] data);
        wait_ready();
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd   <= cmd;
        req_data  <= data;
        @(posedge clk);
        req_valid <= 1'b0;
        wait_ready();
    endtask : send
    // Reference CCITT CRC, one image bit per step, most significant first
    function automatic logic [15:0] ref_crc(input logic [159:0] d);
        logic [15:0] c;
        c = `OCC_CRC_INIT;
        for (int i = 159; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `OCC_CRC_POLY : 16'h0);
        end
        return c;
    endfunction : ref_crc
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check("dbuf", ram_double_buffering, 1'b0);
        check("mode", waveform_state_mode, 36'h0);
        check("busy", link_if.busy, 1'b0);
    endtask : t_reset
    // Enable set but every state in mode 1: double-buffering must stay off
    task automatic t_dbuf_mode1();
        send(`OCC_CMD_WR_OPTION, {8'h00, 32'h0, 8'h40, 32'h0});
        check("dbuf_m1", ram_double_buffering, 1'b0);
        check("mode_m1", waveform_state_mode, 36'h0);
    endtask : t_dbuf_mode1
    task automatic t_option();
        opt_v = {8'h5a, 8'h81, 8'h42, 8'h24, 8'h18, 8'h4a, 32'hc3e1_0f96};
        send(`OCC_CMD_WR_OPTION, opt_v);
        check("mode", waveform_state_mode, {4'ha, 8'h18, 8'h24, 8'h42, 8'h81});
        check("dbuf", ram_double_buffering, 1'b1);
        check("version", module_version, 32'hc3e1_0f96);
    endtask : t_option
    task automatic t_uid_prog();
        int s0;
        send(`OCC_CMD_WR_USER_IDENTIFIER, 80'h0123_4567_89ab_cdef_fedc);
        // Internal clock still off: programming must not strobe the OTP
        s0 = strobes;
        send(`OCC_CMD_OTP_PROG, 80'h0);
        check("strobe_off", strobes - s0, 0);
        @(posedge clk);
        internal_clock_enabled <= 1'b1;
        s0 = strobes;
        send(`OCC_CMD_OTP_PROG, 80'h0);
        repeat (2) @(posedge clk);
        check("strobes", strobes - s0, 1);
        check("prog_data", otp_prog_data, {opt_v, 80'h0123_4567_89ab_cdef_fedc});
    endtask : t_uid_prog
    task automatic t_crc();
        int n;
        send(`OCC_CMD_CRC_CALC, 80'h0);
        check("crc_reg", otp_checksum_result, ref_crc(otp_image));
        n = crc_hits;
        send(`OCC_CMD_CRC_READ, 80'h0);
        repeat (30) if (crc_hits == n) @(posedge clk);
        #1;
        check("crc_done", crc_hits - n, 1);
        check("crc_value", crc_value, ref_crc(otp_image));
    endtask : t_crc
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_cmd = 8'h00;
        req_data = 80'h0;
        internal_clock_enabled = 1'b0;
        otp_image = 160'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834_1082_276b;
        mismatches = 0;
        checked = 0;
        strobes = 0;
        crc_hits = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_dbuf_mode1();
        t_option();
        t_uid_prog();
        t_crc();
        finish_test();
    end
endmodule : testbench
